// ---- include/hiwb_map.svh ----
// register offsets, field positions and reset values of the isochronous write-back block
`ifndef HIWB_MAP_SVH
`define HIWB_MAP_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define HIWB_OFS_DW1 8'h04
`define HIWB_OFS_DW4 8'h10
`define HIWB_OFS_DW5 8'h14
`define HIWB_OFS_DW6 8'h18
`define HIWB_OFS_DW7 8'h1C
`define HIWB_OFS_IRQ_STAT 8'h20
`define HIWB_OFS_IRQ_MASK 8'h24

// ----------------------------------------
// field positions inside the 128-bit view {dw7, dw6, dw5, dw4}, frame field inside word1
// ----------------------------------------
`define HIWB_CNT_BASE 32
`define HIWB_CNT_STEP 12
`define HIWB_CNT_W 12
`define HIWB_RES_BASE 8
`define HIWB_RES_STEP 3
`define HIWB_RES_W 3
`define HIWB_MASK_LSB 0
`define HIWB_FRAME_MSB 7
`define HIWB_FRAME_LSB 3

// ----------------------------------------
// interrupt status bits and reset values
// ----------------------------------------
`define HIWB_IRQ_DONE 0
`define HIWB_IRQ_ERR 1
`define HIWB_IRQ_SKIP 2
`define HIWB_RST_WORD 32'h0000_0000
`define HIWB_RST_IRQ 3'h0

`endif

// ---- include/hiwb_pkg.sv ----
// types shared by the isochronous write-back block
package hiwb_pkg;

    // register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } hiwb_regbus_t;

    // end-of-microframe report from the transaction engine
    typedef struct packed {
        logic done;
        logic [2:0] index;
        logic is_in;
        logic [11:0] count;
        logic err;
        logic babble;
        logic underrun;
    } hiwb_uframe_t;

    // complete block state
    typedef struct packed {
        logic [31:0] dw1;
        logic [127:0] dw47;
        logic [2:0] irq_stat;
        logic [2:0] irq_mask;
        logic [31:0] rdata;
    } hiwb_state_t;

endpackage : hiwb_pkg

// ---- hdl/hiwb_writeback.sv ----
// descriptor write-back of high-speed isochronous microframe results
//
// Notes on behaviour
// [RULE_01] slot 7 count to word7 bits 63:52
// [RULE_02] slot 6 count to word7 bits 51:40
// [RULE_03] slot 5 count high byte to word7 39:32
// [RULE_04] slot 5 count low nibble to word6 31:28
// [RULE_05] slot 4 count to word6 bits 27:16
// [RULE_06] slot 3 count to word6 bits 15:4
// [RULE_07] slot 2 count high nibble to word6 3:0
// [RULE_08] slot 2 count low byte to word5 63:56
// [RULE_09] slot 1 count to word5 bits 55:44
// [RULE_10] slot 0 count to word5 bits 43:32
// [RULE_11] microframe 7 result to word4 bits 31:29
// [RULE_12] microframe 6 result to word4 bits 28:26
// [RULE_13] result: error, babble on IN, underrun on OUT
// [RULE_14] software sets mask bits, hardware clears when done
// [RULE_15] mask honoured only when word1 frame matches bus
`timescale 1ns/1ps
`include "hiwb_map.svh"

module hiwb_writeback (
    input wire logic clock, // core clock, 40 MHz
    input wire logic sys_rst, // synchronous reset, active high
    input wire hiwb_pkg::hiwb_regbus_t reg_req, // register port request
    output logic [31:0] reg_rdata, // read data, cycle after read strobe
    input wire hiwb_pkg::hiwb_uframe_t uf_rep, // end-of-microframe report
    input wire logic [4:0] bus_frame, // current bus frame number
    input wire logic [2:0] cur_uframe, // microframe about to be serviced
    output logic send_ok, // current microframe may be sent
    output logic irq // level interrupt
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    hiwb_pkg::hiwb_state_t st_ff;
    hiwb_pkg::hiwb_state_t nxt_st;

    logic frame_ok;
    logic accept;
    logic [2:0] result;
    logic [7:0] uframe_active_mask;

    assign uframe_active_mask = st_ff.dw47[`HIWB_MASK_LSB +: 8];
    // frame number in word1 must match the bus before any mask bit counts
    assign frame_ok = (st_ff.dw1[`HIWB_FRAME_MSB:`HIWB_FRAME_LSB] == bus_frame); // RULE_15
    assign send_ok = frame_ok && uframe_active_mask[cur_uframe]; // RULE_15
    assign accept = uf_rep.done && frame_ok && uframe_active_mask[uf_rep.index]; // RULE_15
    // babble only counts on IN, underrun only on OUT
    assign result = {uf_rep.underrun & ~uf_rep.is_in, uf_rep.babble & uf_rep.is_in, uf_rep.err}; // RULE_13

    assign reg_rdata = st_ff.rdata;
    assign irq = |(st_ff.irq_stat & st_ff.irq_mask);

    // ----------------------------------------
    // field placement
    // ----------------------------------------
    // slots 2 and 5 straddle a word boundary, the 128-bit view keeps them contiguous
    function automatic logic [6:0] cnt_lsb(input logic [2:0] idx);
        logic [6:0] pos;
        pos = 7'd32;
        case (idx)
            3'd0: pos = 7'(`HIWB_CNT_BASE); // RULE_10
            3'd1: pos = 7'(`HIWB_CNT_BASE + `HIWB_CNT_STEP); // RULE_09
            3'd2: pos = 7'(`HIWB_CNT_BASE + 2 * `HIWB_CNT_STEP); // RULE_07 RULE_08
            3'd3: pos = 7'(`HIWB_CNT_BASE + 3 * `HIWB_CNT_STEP); // RULE_06
            3'd4: pos = 7'(`HIWB_CNT_BASE + 4 * `HIWB_CNT_STEP); // RULE_05
            3'd5: pos = 7'(`HIWB_CNT_BASE + 5 * `HIWB_CNT_STEP); // RULE_03 RULE_04
            3'd6: pos = 7'(`HIWB_CNT_BASE + 6 * `HIWB_CNT_STEP); // RULE_02
            3'd7: pos = 7'(`HIWB_CNT_BASE + 7 * `HIWB_CNT_STEP); // RULE_01
            default: pos = 7'(`HIWB_CNT_BASE);
        endcase
        return pos;
    endfunction : cnt_lsb

    function automatic logic [6:0] res_lsb(input logic [2:0] idx);
        logic [6:0] pos;
        pos = 7'(`HIWB_RES_BASE) + 7'(`HIWB_RES_STEP) * {4'h0, idx}; // RULE_11 RULE_12
        return pos;
    endfunction : res_lsb

    // ----------------------------------------
    // next state
    // ----------------------------------------
    // software writes first, hardware write-back afterwards so it wins a collision
    always_comb begin
        nxt_st = st_ff;
        nxt_st.rdata = `HIWB_RST_WORD;
        if (reg_req.wr) begin
            case (reg_req.addr)
                `HIWB_OFS_DW1: nxt_st.dw1 = reg_req.wdata;
                `HIWB_OFS_DW4: nxt_st.dw47[31:0] = reg_req.wdata; // RULE_14
                `HIWB_OFS_DW5: nxt_st.dw47[63:32] = reg_req.wdata;
                `HIWB_OFS_DW6: nxt_st.dw47[95:64] = reg_req.wdata;
                `HIWB_OFS_DW7: nxt_st.dw47[127:96] = reg_req.wdata;
                `HIWB_OFS_IRQ_STAT: nxt_st.irq_stat = st_ff.irq_stat & ~reg_req.wdata[2:0];
                `HIWB_OFS_IRQ_MASK: nxt_st.irq_mask = reg_req.wdata[2:0];
                default: nxt_st.irq_mask = st_ff.irq_mask;
            endcase
        end
        if (reg_req.rd) begin
            case (reg_req.addr)
                `HIWB_OFS_DW1: nxt_st.rdata = st_ff.dw1;
                `HIWB_OFS_DW4: nxt_st.rdata = st_ff.dw47[31:0];
                `HIWB_OFS_DW5: nxt_st.rdata = st_ff.dw47[63:32];
                `HIWB_OFS_DW6: nxt_st.rdata = st_ff.dw47[95:64];
                `HIWB_OFS_DW7: nxt_st.rdata = st_ff.dw47[127:96];
                `HIWB_OFS_IRQ_STAT: nxt_st.rdata = {29'h0000_0000, st_ff.irq_stat};
                `HIWB_OFS_IRQ_MASK: nxt_st.rdata = {29'h0000_0000, st_ff.irq_mask};
                default: nxt_st.rdata = `HIWB_RST_WORD;
            endcase
        end
        // hardware write-back of a serviced microframe
        if (accept) begin
            if (uf_rep.is_in) begin
                nxt_st.dw47[cnt_lsb(uf_rep.index) +: `HIWB_CNT_W] = uf_rep.count; // RULE_01 RULE_10
            end
            nxt_st.dw47[res_lsb(uf_rep.index) +: `HIWB_RES_W] = result; // RULE_11 RULE_12
            nxt_st.dw47[`HIWB_MASK_LSB + 32'(uf_rep.index)] = 1'b0; // RULE_14
        end
        // sticky events: a set in the cycle of a clear survives
        if (accept) begin
            nxt_st.irq_stat[`HIWB_IRQ_DONE] = 1'b1;
        end
        if (accept && (|result)) begin
            nxt_st.irq_stat[`HIWB_IRQ_ERR] = 1'b1;
        end
        // a report for an unscheduled or wrong-frame microframe is dropped, but flagged
        if (uf_rep.done && !accept) begin
            nxt_st.irq_stat[`HIWB_IRQ_SKIP] = 1'b1; // RULE_15
        end
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            st_ff.dw1 <= `HIWB_RST_WORD;
            st_ff.dw47 <= {4{`HIWB_RST_WORD}};
            st_ff.irq_stat <= `HIWB_RST_IRQ;
            st_ff.irq_mask <= `HIWB_RST_IRQ;
            st_ff.rdata <= `HIWB_RST_WORD;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    sequence s_in_slot(logic [2:0] k);
        accept && uf_rep.is_in && (uf_rep.index == k);
    endsequence

    sequence s_slot(logic [2:0] k);
        accept && (uf_rep.index == k);
    endsequence

    AST_CNT7: assert property (s_in_slot(3'd7) |=> st_ff.dw47[127:116] == $past(uf_rep.count)) // RULE_01
        else $error("slot 7 count misplaced");
    AST_CNT6: assert property (s_in_slot(3'd6) |=> st_ff.dw47[115:104] == $past(uf_rep.count)) // RULE_02
        else $error("slot 6 count misplaced");
    AST_CNT5_HI: assert property (s_in_slot(3'd5) |=> st_ff.dw47[103:96] == $past(uf_rep.count[11:4])) // RULE_03
        else $error("slot 5 high byte misplaced");
    AST_CNT5_LO: assert property (s_in_slot(3'd5) |=> st_ff.dw47[95:92] == $past(uf_rep.count[3:0])) // RULE_04
        else $error("slot 5 low nibble misplaced");
    AST_CNT4: assert property (s_in_slot(3'd4) |=> st_ff.dw47[91:80] == $past(uf_rep.count)) // RULE_05
        else $error("slot 4 count misplaced");
    AST_CNT3: assert property (s_in_slot(3'd3) |=> st_ff.dw47[79:68] == $past(uf_rep.count)) // RULE_06
        else $error("slot 3 count misplaced");
    AST_CNT2_HI: assert property (s_in_slot(3'd2) |=> st_ff.dw47[67:64] == $past(uf_rep.count[11:8])) // RULE_07
        else $error("slot 2 high nibble misplaced");
    AST_CNT2_LO: assert property (s_in_slot(3'd2) |=> st_ff.dw47[63:56] == $past(uf_rep.count[7:0])) // RULE_08
        else $error("slot 2 low byte misplaced");
    AST_CNT1: assert property (s_in_slot(3'd1) |=> st_ff.dw47[55:44] == $past(uf_rep.count)) // RULE_09
        else $error("slot 1 count misplaced");
    AST_CNT0: assert property (s_in_slot(3'd0) |=> st_ff.dw47[43:32] == $past(uf_rep.count)) // RULE_10
        else $error("slot 0 count misplaced");
    AST_RES7: assert property (s_slot(3'd7) |=> st_ff.dw47[31:29] == $past(result)) // RULE_11
        else $error("microframe 7 result misplaced");
    AST_RES6: assert property (s_slot(3'd6) |=> st_ff.dw47[28:26] == $past(result)) // RULE_12
        else $error("microframe 6 result misplaced");
    AST_RES_OUT: assert property (s_slot(3'd6) ##0 !uf_rep.is_in |=> !st_ff.dw47[27]
        && (st_ff.dw47[28] == $past(uf_rep.underrun)) && (st_ff.dw47[26] == $past(uf_rep.err))) // RULE_13
        else $error("OUT result encoding wrong");
    AST_MASK_CLR: assert property (accept |=> !uframe_active_mask[$past(uf_rep.index)]
        && st_ff.irq_stat[`HIWB_IRQ_DONE]) // RULE_14
        else $error("mask bit not cleared after service");
    AST_NO_MATCH: assert property (uf_rep.done && !frame_ok && !reg_req.wr |=> st_ff.dw47 == $past(st_ff.dw47)
        ##0 st_ff.irq_stat[`HIWB_IRQ_SKIP]) // RULE_15
        else $error("wrong-frame report altered descriptor");
    AST_SEND: assert property (send_ok |-> st_ff.dw1[7:3] == bus_frame) // RULE_15
        else $error("send allowed on wrong frame");

endmodule : hiwb_writeback

// ---- testbench/hiwb_dev_model.sv ----
// behavioural isochronous device that closes each microframe with a report
`timescale 1ns/1ps

module hiwb_dev_model (
    input wire logic clock, // core clock
    output hiwb_pkg::hiwb_uframe_t uf_rep // end-of-microframe report
);
    initial uf_rep = '0;

    // one pulse per call; the released lines show inverted index, direction and count and cleared flags, not stale data
    task send(input logic [2:0] idx, input logic in, input logic [11:0] cnt, input logic [2:0] flg);
        @(posedge clock);
        uf_rep <= '{done: 1'b1, index: idx, is_in: in, count: cnt, err: flg[0],
                    babble: flg[1] & in, underrun: flg[2] & ~in};
        @(posedge clock);
        uf_rep <= '{done: 1'b0, index: ~idx, is_in: ~in, count: ~cnt, err: 1'b0, babble: 1'b0, underrun: 1'b0};
    endtask : send
endmodule : hiwb_dev_model

// ---- testbench/hiwb_writeback_tb.sv ----
// self-checking bench of the isochronous descriptor write-back block
`timescale 1ns/1ps
`include "hiwb_map.svh"

module hiwb_writeback_tb;
    typedef struct packed {
        logic [2:0] idx;
        logic is_in;
        logic [11:0] cnt;
        logic [2:0] flg; // {underrun, babble, error}
    } hiwb_row_t;
    logic clock;
    logic sys_rst;
    hiwb_pkg::hiwb_regbus_t reg_req;
    hiwb_pkg::hiwb_uframe_t uf_rep;
    logic [31:0] reg_rdata;
    logic [4:0] bus_frame;
    logic [2:0] cur_uframe;
    logic send_ok;
    logic irq;
    logic [127:0] exp_d;
    logic [2:0] exp_irq;
    logic [2:0] res;
    int err_total;
    int checks_done;
    // every slot once; flags cover error and babble on IN, underrun alone and with error on OUT
    hiwb_row_t rows [8] = '{{3'h0, 1'b1, 12'h0AB, 3'h0}, {3'h1, 1'b1, 12'hFFF, 3'h1},
                            {3'h2, 1'b1, 12'h5A3, 3'h2}, {3'h3, 1'b0, 12'h123, 3'h4},
                            {3'h4, 1'b1, 12'h800, 3'h7}, {3'h5, 1'b1, 12'hABC, 3'h0},
                            {3'h6, 1'b0, 12'h777, 3'h7}, {3'h7, 1'b1, 12'h001, 3'h0}};

    hiwb_writeback hiwb_writeback_i (.clock(clock), .sys_rst(sys_rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .uf_rep(uf_rep), .bus_frame(bus_frame), .cur_uframe(cur_uframe), .send_ok(send_ok), .irq(irq));
    hiwb_dev_model hiwb_dev_model_i (.clock(clock), .uf_rep(uf_rep));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock);
        reg_req.wr <= 1'b0;
    endtask : wr

    // read data stand only in the cycle after the strobe
    task rd(input string name, input logic [7:0] a, input logic [31:0] exp);
        @(posedge clock);
        reg_req <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
        @(posedge clock);
        reg_req.rd <= 1'b0;
        #1 chk(name, reg_rdata, exp);
    endtask : rd

    task rd_desc(input string name);
        for (int w = 0; w < 4; w++) rd(name, `HIWB_OFS_DW4 + 8'(4 * w), exp_d[32 * w +: 32]);
    endtask : rd_desc

    task results();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : results

    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    // watchdog: the whole sequence needs well under 500 cycles
    initial begin
        repeat (5000) @(posedge clock);
        err_total++;
        results();
    end

    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        reg_req = '0;
        bus_frame = 5'h0A;
        cur_uframe = 3'h3;
        sys_rst = 1'b1;
        exp_d = '0;
        exp_irq = 3'h0;
        err_total = 0;
        checks_done = 0;
        repeat (4) @(posedge clock);
        sys_rst <= 1'b0;
        rd_desc("reset word");
        // read data must fall back to zero one cycle after it stood
        @(posedge clock);
        #1 chk("idle rdata", reg_rdata, 32'h0000_0000);
        wr(`HIWB_OFS_DW1, 32'h0000_0050);
        wr(`HIWB_OFS_DW4, 32'h0000_00FF);
        exp_d[7:0] = 8'hFF;
        rd("word1", `HIWB_OFS_DW1, 32'h0000_0050);
        chk("send_ok set", 32'(send_ok), 32'h0000_0001);
        foreach (rows[r]) begin
            hiwb_dev_model_i.send(rows[r].idx, rows[r].is_in, rows[r].cnt, rows[r].flg);
            res = {rows[r].flg[2] & ~rows[r].is_in, rows[r].flg[1] & rows[r].is_in, rows[r].flg[0]};
            if (rows[r].is_in) exp_d[32 + 12 * rows[r].idx +: 12] = rows[r].cnt;
            exp_d[8 + 3 * rows[r].idx +: 3] = res;
            exp_d[rows[r].idx] = 1'b0;
            exp_irq = exp_irq | {1'b0, res != 3'h0, 1'b1};
            rd_desc("descriptor");
            $display("slot %0d done", r);
        end
        // sticky status held back by the mask, then released and cleared
        rd("irq stat", `HIWB_OFS_IRQ_STAT, {29'h0000_0000, exp_irq});
        chk("irq masked", 32'(irq), 32'h0000_0000);
        wr(`HIWB_OFS_IRQ_MASK, 32'h0000_0007);
        rd("irq mask", `HIWB_OFS_IRQ_MASK, 32'h0000_0007);
        chk("irq on", 32'(irq), 32'h0000_0001);
        wr(`HIWB_OFS_IRQ_STAT, 32'h0000_0007);
        rd("irq clr", `HIWB_OFS_IRQ_STAT, 32'h0000_0000);
        chk("irq off", 32'(irq), 32'h0000_0000);
        $display("interrupt test done");
        // mask cleared by hardware, then a wrong frame: reports are dropped
        chk("send_ok spent", 32'(send_ok), 32'h0000_0000);
        hiwb_dev_model_i.send(3'h3, 1'b1, 12'h321, 3'h0);
        rd_desc("spent slot");
        // rearm slots 3 and 6 for an IN pass, the first pass ran them as OUT
        exp_d[3] = 1'b1;
        exp_d[6] = 1'b1;
        wr(`HIWB_OFS_DW4, exp_d[31:0]);
        hiwb_dev_model_i.send(3'h3, 1'b1, 12'h321, 3'h0);
        hiwb_dev_model_i.send(3'h6, 1'b1, 12'h9E5, 3'h2);
        exp_d[32 + 36 +: 12] = 12'h321;
        exp_d[8 + 9 +: 3] = 3'h0;
        exp_d[3] = 1'b0;
        exp_d[32 + 72 +: 12] = 12'h9E5;
        exp_d[8 + 18 +: 3] = 3'h2;
        exp_d[6] = 1'b0;
        rd_desc("rearmed slots");
        exp_d[3] = 1'b1;
        wr(`HIWB_OFS_DW4, exp_d[31:0]);
        rd("skip stat", `HIWB_OFS_IRQ_STAT, 32'h0000_0007);
        chk("send_ok rearm", 32'(send_ok), 32'h0000_0001);
        bus_frame <= 5'h0B;
        hiwb_dev_model_i.send(3'h3, 1'b1, 12'h321, 3'h0);
        rd_desc("wrong frame");
        chk("send_ok frame", 32'(send_ok), 32'h0000_0000);
        rd("unmapped", 8'h3C, 32'h0000_0000);
        $display("drop test done");
        // second reset in mid-run
        @(posedge clock);
        sys_rst <= 1'b1;
        @(posedge clock);
        sys_rst <= 1'b0;
        exp_d = '0;
        rd_desc("rerun reset");
        rd("rerun word1", `HIWB_OFS_DW1, 32'h0000_0000);
        chk("rerun irq", 32'(irq), 32'h0000_0000);
        $display("reset test done");
        results();
    end
endmodule : hiwb_writeback_tb
